// *** rtl/ddrmr_pkg.sv ***
// Constants shared by the mode-register and driver-calibration logic.
// Assumes a single 250 MHz system clock; no bus, all control bits are ports.
package ddrmr_pkg;

   // ****************************************
   // Command and field layout
   // ****************************************
   localparam int ADDR_W        = 13;
   localparam int BA_W          = 2;
   localparam int DQ_W          = 16;
   localparam int STEP_W        = 4;
   // Bank-address codes selecting each register
   localparam logic [1:0] SEL_MR   = 2'h0;
   localparam logic [1:0] SEL_EMR1 = 2'h1;
   localparam logic [1:0] SEL_EMR2 = 2'h2;
   localparam logic [1:0] SEL_EMR3 = 2'h3;
   // Main register fields
   localparam int MR_SPAN_LSB   = 0;
   localparam int MR_BT_BIT     = 3;
   localparam int MR_RDLAT_LSB  = 4;
   localparam int MR_TM_BIT     = 7;
   localparam int MR_DLLRST_BIT = 8;
   localparam int MR_WR_LSB     = 9;
   // Extended register 1 fields
   localparam int E1_DLLDIS_BIT = 0;
   localparam int E1_DRV_BIT    = 1;
   localparam int E1_RTT0_BIT   = 2;
   localparam int E1_POST_LSB   = 3;
   localparam int E1_RTT1_BIT   = 6;
   localparam int E1_OCD_LSB    = 7;
   localparam int E1_NDQS_BIT   = 10;
   localparam int E1_QOFF_BIT   = 12;
   // Extended register 2 field
   localparam int E2_HTSR_BIT   = 7;
   // Burst span codes
   localparam logic [2:0] SPAN_CODE4 = 3'h2;
   localparam logic [2:0] SPAN_CODE8 = 3'h3;
   // Calibration codes in A9..A7
   localparam logic [2:0] OCD_EXIT    = 3'h0;
   localparam logic [2:0] OCD_DRIVE1  = 3'h1;
   localparam logic [2:0] OCD_DRIVE0  = 3'h2;
   localparam logic [2:0] OCD_ADJUST  = 3'h4;
   localparam logic [2:0] OCD_DEFAULT = 3'h7;
   // Reset values: contents are undefined at power-up, zero chosen for registers, 8 for the step counters
   localparam logic [12:0] MR_RESET   = 13'h0000;
   localparam logic [3:0]  STEP_RESET = 4'h8;
   localparam logic [3:0]  STEP_DEF   = 4'h8;
   localparam logic [3:0]  STEP_MAX   = 4'hf;
   localparam logic [3:0]  STEP_MIN   = 4'h0;
   localparam int DLL_LOCK_CYC  = 200;

   typedef enum logic [1:0] {
      DDRMR_DRV_OFF = 2'h0,
      DDRMR_DRV_HI  = 2'h1,
      DDRMR_DRV_LO  = 2'h3
   } ddrmr_drive_t;

endpackage

// *** rtl/ddrmr_sync.sv ***
// Two-stage synchroniser with rising-edge detect on the synchronised level.
// Assumes the input is asynchronous to clk_sys_i.
`timescale 1ns/100ps
module ddrmr_sync (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Level in, level and edge out
   input  wire logic din_i,
   output logic      dout_o,
   output logic      rise_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } ddrmr_sync_t;

   ddrmr_sync_t st, next_st;

   // ****************************************
   // Capture chain; s1 feeds only s2
   // ****************************************
   always_comb begin
      next_st    = st;
      next_st.s1 = din_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout_o = st.s2;
   assign rise_o = st.s2 & ~st.s3;
endmodule // ddrmr_sync

// *** rtl/ddrmr_step.sv ***
// Saturating four-bit driver step counter with default load.
// Assumes inc and dec come as one-cycle pulses on clk_sys_i.
`timescale 1ns/100ps
module ddrmr_step
   import ddrmr_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // Control
   input  wire logic              load_def_i,
   input  wire logic              inc_i,
   input  wire logic              dec_i,
   // Setting
   output logic [STEP_W-1:0]      step_o
);
   logic [STEP_W-1:0] step, next_step;

   // ****************************************
   // Step update, holds at either end
   // ****************************************
   always_comb begin
      next_step = step;
      if (load_def_i) begin
         next_step = STEP_DEF;
      end else if (inc_i && !dec_i && step != STEP_MAX) begin
         next_step = step + 4'h1;
      end else if (dec_i && !inc_i && step != STEP_MIN) begin
         next_step = step - 4'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step <= STEP_RESET;
      end else begin
         step <= next_step;
      end
   end

   assign step_o = step;

   a_step_sat_hi: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (step == STEP_MAX && inc_i && !dec_i && !load_def_i) |=> step == STEP_MAX)
      else $error("step passed upper limit");
   a_step_sat_lo: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (step == STEP_MIN && dec_i && !inc_i && !load_def_i) |=> step == STEP_MIN)
      else $error("step passed lower limit");
endmodule // ddrmr_step

// *** rtl/ddrmr_top.sv ***
// Mode registers, burst ordering and driver calibration of a DDR2 die.
// Assumes command pins arrive asynchronously with a free link clock pin;
// the 250 MHz system clock samples all of them and finds link clock edges.
//
// How it works
// - all-low command with BA 00 loads main
// - main register holds span, order, latency
// - A7 test bit low; A8 resets DLL
// - A9..A11 give write recovery cycles
// - sequential order wraps in aligned four
// - interleaved order is start XOR beat
// - BA 01 selects extended register one
// - ext one: DLL, drive, latency, calibration, strobe
// - termination chosen by A2 and A6
// - output disable silences data and strobes
// - BA 10 selects ext two, high temp refresh
// - decode calibration code in A9..A7
// - drive modes force data and strobes
// - adjust code applies to every data output
// - sixteen-step driver setting saturates
// - adjust beats decoded in fixed order
// - adjust burst taken at write latency
`timescale 1ns/100ps
module ddrmr_top
   import ddrmr_pkg::*;
(
   // System clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // Link clock and command pins
   input  wire logic              link_clk_i,
   input  wire logic              cke_i,
   input  wire logic              cs_n_i,
   input  wire logic              ras_n_i,
   input  wire logic              cas_n_i,
   input  wire logic              we_n_i,
   input  wire logic [BA_W-1:0]   ba_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   // Adjust burst data, one beat per link clock
   input  wire logic [DQ_W-1:0]   dq_i,
   // Burst start column for ordering
   input  wire logic [2:0]        burst_col_i,
   // Data and strobe drive control
   output logic                   dq_o,
   output logic                   dq_oe_n_o,
   output logic                   dqs_o,
   output logic                   dqs_oe_n_o,
   output logic                   dqs_b_o,
   output logic                   dqs_b_oe_n_o,
   // Decoded settings
   output logic [2:0]             burst_span_o,
   output logic                   burst_interleave_o,
   output logic [2:0]             column_read_latency_o,
   output logic                   test_mode_o,
   output logic                   dll_reset_o,
   output logic [2:0]             write_recovery_o,
   output logic                   dll_enable_o,
   output logic                   drive_reduced_o,
   output logic [2:0]             posted_command_latency_o,
   output logic [1:0]             term_sel_o,
   output logic                   dqs_b_disable_o,
   output logic                   out_disable_o,
   output logic                   hi_temp_refresh_o,
   output logic [ADDR_W-1:0]      ext3_o,
   output logic                   calib_active_o,
   output logic [STEP_W-1:0]      pullup_step_o,
   output logic [STEP_W-1:0]      pulldown_step_o,
   // Burst column order, eight beats of three bits
   output logic [23:0]            burst_order_o
);
   // ****************************************
   // Reset release and pin capture
   // ****************************************
   logic [1:0] rst_pipe;
   logic       rst_n;

   // Release through two flops so every flop on rst_n leaves reset on one edge
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   localparam int PIN_N = 5 + BA_W + ADDR_W + DQ_W;
   logic [PIN_N-1:0] pin_s1, pin_s2;
   logic             link_rise;

   // Pins change only around falling link edges, so two flops suffice
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dq_i};
         pin_s2 <= pin_s1;
      end
   end

   ddrmr_sync u_link_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .din_i     (link_clk_i),
      .dout_o    (),
      .rise_o    (link_rise)
   );

   logic                s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n;
   logic [BA_W-1:0]     s_ba;
   logic [ADDR_W-1:0]   s_addr;
   logic [DQ_W-1:0]     s_dq;
   assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr, s_dq} = pin_s2;

   // Command decode on link rising edge
   logic load_cmd, write_cmd;
   assign load_cmd  = link_rise && s_cke && !s_cs_n && !s_ras_n && !s_cas_n && !s_we_n;
   assign write_cmd = link_rise && s_cke && !s_cs_n && s_ras_n && !s_cas_n && !s_we_n;

   // ****************************************
   // State
   // ****************************************
   typedef enum logic [1:0] {
      DDRMR_IDLE = 2'h0,
      DDRMR_WAIT = 2'h1,
      DDRMR_BEAT = 2'h3
   } ddrmr_adj_t;

   typedef struct packed {
      logic [ADDR_W-1:0] mr;
      logic [ADDR_W-1:0] e1;
      logic [ADDR_W-1:0] e2;
      logic [ADDR_W-1:0] e3;
      ddrmr_adj_t        adj;
      logic [3:0]        wait_cnt;
      logic [1:0]        beat;
      logic [3:0]        code;
      logic              pu_inc, pu_dec, pd_inc, pd_dec, def_load;
      ddrmr_drive_t      drive;
   } ddrmr_state_t;

   ddrmr_state_t st, next_st;
   logic [2:0] ocd_code, rd_lat, post_lat, span_code;
   logic [3:0] wl;

   assign ocd_code  = st.e1[E1_OCD_LSB +: 3];
   assign rd_lat    = st.mr[MR_RDLAT_LSB +: 3];
   assign post_lat  = st.e1[E1_POST_LSB +: 3];
   assign span_code = st.mr[MR_SPAN_LSB +: 3];
   // Write latency is posted latency plus read latency minus one
   assign wl = 4'({1'b0, post_lat} + {1'b0, rd_lat} - 4'h1);

   // ****************************************
   // Register loads and calibration control
   // ****************************************
   always_comb begin
      next_st          = st;
      next_st.pu_inc   = 1'b0;
      next_st.pu_dec   = 1'b0;
      next_st.pd_inc   = 1'b0;
      next_st.pd_dec   = 1'b0;
      next_st.def_load = 1'b0;
      if (load_cmd) begin
         // Only the selected register takes the address
         unique case (s_ba)
            SEL_MR:   next_st.mr = s_addr;
            SEL_EMR1: next_st.e1 = s_addr;
            SEL_EMR2: next_st.e2 = s_addr;
            SEL_EMR3: next_st.e3 = s_addr;
         endcase
         if (s_ba == SEL_EMR1) begin
            next_st.adj   = DDRMR_IDLE;
            next_st.drive = DDRMR_DRV_OFF;
            next_st.wait_cnt = 4'h0; // A cut burst must not leave a count armed
            unique case (s_addr[E1_OCD_LSB +: 3])
               OCD_DRIVE1:  next_st.drive = DDRMR_DRV_HI;
               OCD_DRIVE0:  next_st.drive = DDRMR_DRV_LO;
               OCD_ADJUST:  next_st.adj = DDRMR_WAIT;
               OCD_DEFAULT: next_st.def_load = 1'b1;
               default:     next_st.drive = DDRMR_DRV_OFF; // Exit and undefined codes
            endcase
         end
      end else begin
         unique case (st.adj)
            DDRMR_IDLE: next_st.adj = DDRMR_IDLE;
            // Adjust burst follows the next write after latency
            DDRMR_WAIT: begin
               if (write_cmd) begin
                  // First beat lands wl link edges after the write; zero latency
                  // cannot be met and falls back to the next edge
                  next_st.wait_cnt = (wl > 4'h1) ? wl - 4'h1 : 4'h0;
                  next_st.beat     = 2'h0;
                  next_st.adj      = (wl > 4'h1) ? DDRMR_WAIT : DDRMR_BEAT;
               end else if (link_rise && st.wait_cnt != 4'h0) begin
                  next_st.wait_cnt = st.wait_cnt - 4'h1;
                  if (st.wait_cnt == 4'h1) next_st.adj = DDRMR_BEAT;
               end
            end
            // Beats taken in fixed order, only DQ0 carries the code
            DDRMR_BEAT: begin
               if (link_rise) begin
                  next_st.code[st.beat] = s_dq[0];
                  next_st.beat          = st.beat + 2'h1;
                  if (st.beat == 2'h3) begin
                     next_st.adj = DDRMR_WAIT;
                     next_st.wait_cnt = 4'h0;
                     unique case ({st.code[0], st.code[1], st.code[2], s_dq[0]})
                        4'h1: next_st.pu_inc = 1'b1; // 0001
                        4'h2: next_st.pu_dec = 1'b1;
                        4'h4: next_st.pd_inc = 1'b1;
                        4'h8: next_st.pd_dec = 1'b1;
                        4'h5: begin next_st.pu_inc = 1'b1; next_st.pd_inc = 1'b1; end
                        4'h6: begin next_st.pu_dec = 1'b1; next_st.pd_inc = 1'b1; end
                        4'h9: begin next_st.pu_inc = 1'b1; next_st.pd_dec = 1'b1; end
                        4'ha: begin next_st.pu_dec = 1'b1; next_st.pd_dec = 1'b1; end
                        default: next_st.pu_inc = 1'b0; // No step and reserved
                     endcase
                  end
               end
            end
            default: next_st.adj = DDRMR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{mr: MR_RESET, e1: MR_RESET, e2: MR_RESET, e3: MR_RESET,
                 adj: DDRMR_IDLE, drive: DDRMR_DRV_OFF, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Driver step counters
   // ****************************************
   ddrmr_step u_pullup (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n),
      .load_def_i (st.def_load),
      .inc_i      (st.pu_inc),
      .dec_i      (st.pu_dec),
      .step_o     (pullup_step_o)
   );
   ddrmr_step u_pulldown (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n),
      .load_def_i (st.def_load),
      .inc_i      (st.pd_inc),
      .dec_i      (st.pd_dec),
      .step_o     (pulldown_step_o)
   );

   // ****************************************
   // Decoded fields and pin drive
   // ****************************************
   assign burst_span_o             = span_code;
   assign burst_interleave_o       = st.mr[MR_BT_BIT];
   assign column_read_latency_o    = rd_lat;
   assign test_mode_o              = st.mr[MR_TM_BIT];
   assign dll_reset_o              = st.mr[MR_DLLRST_BIT];
   assign write_recovery_o         = st.mr[MR_WR_LSB +: 3];
   assign dll_enable_o             = ~st.e1[E1_DLLDIS_BIT];
   assign drive_reduced_o          = st.e1[E1_DRV_BIT];
   assign posted_command_latency_o = post_lat;
   assign term_sel_o               = {st.e1[E1_RTT1_BIT], st.e1[E1_RTT0_BIT]};
   assign dqs_b_disable_o          = st.e1[E1_NDQS_BIT];
   assign out_disable_o            = st.e1[E1_QOFF_BIT];
   assign hi_temp_refresh_o        = st.e2[E2_HTSR_BIT];
   assign ext3_o                   = st.e3;
   assign calib_active_o           = (ocd_code != OCD_EXIT);

   // Output disable overrides the forced drive modes
   logic drv_on;
   assign drv_on       = (st.drive != DDRMR_DRV_OFF) && !out_disable_o;
   assign dq_o         = (st.drive == DDRMR_DRV_HI);
   assign dqs_o        = (st.drive == DDRMR_DRV_HI);
   assign dqs_b_o      = (st.drive == DDRMR_DRV_LO);
   assign dq_oe_n_o    = ~drv_on;
   assign dqs_oe_n_o   = ~drv_on;
   assign dqs_b_oe_n_o = ~(drv_on && !dqs_b_disable_o);

   // Burst column order per beat
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_order
         logic [2:0] seq, ilv, col;
         assign seq = {burst_col_i[2] ^ 1'(g >> 2), 2'(burst_col_i[1:0] + 2'(g))};
         assign ilv = burst_col_i ^ 3'(g);
         assign col = st.mr[MR_BT_BIT] ? ilv : seq;
         assign burst_order_o[3*g +: 3] = (span_code == SPAN_CODE4 && g >= 4) ? 3'h0
                                          : (span_code == SPAN_CODE4) ? {1'b0, col[1:0]} : col;
      end
   endgenerate

   // ****************************************
   // Checks
   // ****************************************
   a_mr_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba == SEL_MR) |=> st.mr == $past(s_addr))
      else $error("main register not loaded");
   a_e1_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba != SEL_EMR1) |=> $stable(st.e1))
      else $error("ext one changed by other load");
   a_e1_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba == SEL_EMR1) |=> st.e1 == $past(s_addr))
      else $error("ext one not loaded");
   a_qoff_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      out_disable_o |-> dq_oe_n_o && dqs_oe_n_o && dqs_b_oe_n_o)
      else $error("outputs driven while disabled");
   a_drive_hi: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba == SEL_EMR1 && s_addr[E1_OCD_LSB +: 3] == OCD_DRIVE1)
      |=> dq_o && dqs_o && !dqs_b_o)
      else $error("drive high pattern wrong");
   a_ilv_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (st.mr[MR_BT_BIT] && span_code == SPAN_CODE8)
      |-> burst_order_o[5:3] == (burst_col_i ^ 3'h1))
      else $error("interleave beat one wrong");
   a_e2_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba == SEL_EMR2) |=> hi_temp_refresh_o == $past(s_addr[E2_HTSR_BIT]))
      else $error("high temp bit not loaded");
   a_adj_enter: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (load_cmd && s_ba == SEL_EMR1 && s_addr[E1_OCD_LSB +: 3] == OCD_ADJUST)
      |=> st.adj == DDRMR_WAIT)
      else $error("adjust mode not entered");

   c_adjust: cover property (@(posedge clk_sys_i) disable iff (!rst_n) st.pu_inc);
   c_default: cover property (@(posedge clk_sys_i) disable iff (!rst_n) st.def_load);
   c_drive_lo: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
      st.drive == DDRMR_DRV_LO);
endmodule // ddrmr_top

// *** sim/ddrmr_ctl_model.sv ***
// Controller model: free link clock, command pins, adjust bursts.
// Assumes clk_sys_i is the design's system clock; pins move after it rises.
`timescale 1ns/100ps
module ddrmr_ctl_model
   import ddrmr_pkg::*;
(
   // System clock
   input  wire logic              clk_sys_i,
   // Link clock and command pins
   output logic                   link_clk_o,
   output logic                   cke_o,
   output logic                   cs_n_o,
   output logic                   ras_n_o,
   output logic                   cas_n_o,
   output logic                   we_n_o,
   output logic [BA_W-1:0]        ba_o,
   output logic [ADDR_W-1:0]      addr_o,
   // Adjust burst data
   output logic [DQ_W-1:0]        dq_o
);
   // ********
   // Link clock and idle pins
   // ********
   // Odd offset keeps link edges off system clock edges
   initial begin
      link_clk_o = 1'b0;
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = 3'h7;
      ba_o = 2'h0;
      addr_o = 13'h0000;
      dq_o = 16'h0000;
      #1.3;
      forever #16 link_clk_o = ~link_clk_o;
   end

   // Pins change mid link cycle, never near its rising edge
   task automatic edge_fall();
      @(negedge link_clk_o);
      @(posedge clk_sys_i);
   endtask

   // One command, then deselect; the bench also sends reads through it
   task automatic send(input logic [2:0] rcw, input logic [1:0] ba, input logic [12:0] a);
      edge_fall();
      cs_n_o <= 1'b0;
      {ras_n_o, cas_n_o, we_n_o} <= rcw;
      ba_o <= ba;
      addr_o <= a;
      edge_fall();
      cs_n_o <= 1'b1;
      {ras_n_o, cas_n_o, we_n_o} <= 3'h7;
      ba_o <= ~ba;
      addr_o <= ~a; // Released pins show no stale value
      repeat (2) edge_fall();
   endtask

   // Adjust mode, write, four beats on all lines, then exit; first beat one
   // link edge after the write, so the bench keeps write latency at one
   task automatic adjust(input logic [12:0] e1, input logic [3:0] d);
      int g;
      send(3'h0, SEL_EMR1, e1 | 13'h0200);
      edge_fall();
      cs_n_o <= 1'b0;
      {ras_n_o, cas_n_o, we_n_o} <= 3'h4;
      for (g = 0; g < 4; g++) begin
         edge_fall();
         cs_n_o <= 1'b1;
         {ras_n_o, cas_n_o, we_n_o} <= 3'h7;
         dq_o <= {DQ_W{d[3-g]}};
      end
      edge_fall();
      dq_o <= ~dq_o;
      send(3'h0, SEL_EMR1, e1);
   endtask
endmodule // ddrmr_ctl_model

// *** sim/ddrmr_top_tb_top.sv ***
// Bench for the mode registers and driver calibration, with a model.
// Assumes the controller model drives every command pin.
`timescale 1ns/100ps
module ddrmr_top_tb_top
   import ddrmr_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] burst_col = 3'h0;
   logic link_clk, cke, cs_n, ras_n, cas_n, we_n;
   logic [1:0] ba, term;
   logic [12:0] addr, ext3, mr, e1, e2, e3;
   logic [15:0] dq_in;
   logic dq, dq_oe_n, dqs, dqs_oe_n, dqs_b, dqs_b_oe_n;
   logic [2:0] span, rd_lat, wr, post_lat;
   logic inter, tm, dll_rst, dll_en, drv_red, dqsb_dis, qoff, htsr, calib;
   logic [3:0] pu_step, pd_step, d;
   logic [23:0] order;
   logic [3:0] tail [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h9, 4'h0};
   int pu, pd, err_total, checked, seed, i, g;

   // ********
   // Clock, design and controller
   // ********
   always #2 clk_sys = ~clk_sys;

   ddrmr_top u_dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .link_clk_i(link_clk),
      .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
      .ba_i(ba), .addr_i(addr), .dq_i(dq_in), .burst_col_i(burst_col), .dq_o(dq),
      .dq_oe_n_o(dq_oe_n), .dqs_o(dqs), .dqs_oe_n_o(dqs_oe_n), .dqs_b_o(dqs_b),
      .dqs_b_oe_n_o(dqs_b_oe_n), .burst_span_o(span), .burst_interleave_o(inter),
      .column_read_latency_o(rd_lat), .test_mode_o(tm), .dll_reset_o(dll_rst),
      .write_recovery_o(wr), .dll_enable_o(dll_en), .drive_reduced_o(drv_red),
      .posted_command_latency_o(post_lat), .term_sel_o(term), .dqs_b_disable_o(dqsb_dis),
      .out_disable_o(qoff), .hi_temp_refresh_o(htsr), .ext3_o(ext3),
      .calib_active_o(calib), .pullup_step_o(pu_step), .pulldown_step_o(pd_step),
      .burst_order_o(order));

   ddrmr_ctl_model u_ctl (.clk_sys_i(clk_sys), .link_clk_o(link_clk), .cke_o(cke),
      .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba),
      .addr_o(addr), .dq_o(dq_in));

   task automatic chk(input string nm, input logic [23:0] ex, input logic [23:0] got);
      checked++;
      if (got !== ex) begin
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
         err_total++;
      end
   endtask

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Expected column of every beat from start column, order and span
   function automatic logic [23:0] exp_order(logic [2:0] c, logic il, logic b8);
      logic [23:0] r;
      r = '0;
      for (int k = 0; k < (b8 ? 8 : 4); k++) begin
         r[3*k +: 3] = il ? c ^ 3'(k) : {c[2] ^ k[2], c[1:0] + 2'(k)};
      end
      return r;
   endfunction

   // Step arithmetic that stops at both ends of the range
   function automatic int sat(int v, logic [1:0] c);
      return c == 2'h1 ? (v < 15 ? v + 1 : v) : (c == 2'h2 ? (v > 0 ? v - 1 : v) : v);
   endfunction

   task automatic check_all();
      chk("mr", 24'(mr[11:0]), 24'({wr, dll_rst, tm, rd_lat, inter, span}));
      chk("e1", 24'({e1[12], e1[10], e1[5:3], e1[1], ~e1[0]}),
          24'({qoff, dqsb_dis, post_lat, drv_red, dll_en}));
      chk("term", 24'({e1[6], e1[2]}), 24'(term));
      chk("e2 e3", 24'({e2[7], e3}), 24'({htsr, ext3}));
      chk("calib", 24'(|e1[9:7]), 24'(calib));
      chk("steps", 24'({pu[3:0], pd[3:0]}), 24'({pu_step, pd_step}));
   endtask

   // Load one register, mirror it, compare every register
   task automatic load(input logic [1:0] sel, input logic [12:0] v);
      u_ctl.send(3'h0, sel, v);
      case (sel)
         SEL_MR: mr = v;
         SEL_EMR1: e1 = v;
         SEL_EMR2: e2 = v;
         default: e3 = v;
      endcase
      check_all();
   endtask

   // ********
   // Main sequence
   // ********
   initial begin
      err_total = 0;
      checked = 0;
      seed = 38214;
      {mr, e1, e2, e3} = '0;
      pu = 8;
      pd = 8;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check_all();
      chk("oe", 24'h7, 24'({dq_oe_n, dqs_oe_n, dqs_b_oe_n}));
      // Random loads with reserved bits zero and test bit low
      for (i = 0; i < 24; i++) begin
         g = $random(seed) & 3;
         case (g)
            0: load(SEL_MR, 13'($random(seed)) & 13'h0f7f);
            1: load(SEL_EMR1, 13'($random(seed)) & 13'h147f);
            2: load(SEL_EMR2, 13'($random(seed)) & 13'h0080);
            default: load(SEL_EMR3, 13'h0000);
         endcase
      end
      // Other commands must leave every register alone
      for (g = 1; g < 7; g++) u_ctl.send(3'(g), SEL_MR, 13'h1fff);
      check_all();
      // Burst order for each type and span, start columns 0..7 for span eight, 0..3 for span four
      for (i = 0; i < 4; i++) begin
         load(SEL_MR, {6'h0, 3'h2, i[1], (i[0] ? SPAN_CODE8 : SPAN_CODE4)});
         for (g = 0; g < (i[0] ? 8 : 4); g++) begin
            burst_col <= 3'(g);
            repeat (2) @(posedge clk_sys);
            chk("order", exp_order(3'(g), i[1], i[0]), order);
         end
      end
      load(SEL_MR, 13'h0022);
      load(SEL_EMR1, 13'h0000);
      // Drive high, drive low with complementary strobe off, drive high under output disable
      for (i = 0; i < 3; i++) begin
         load(SEL_EMR1, i == 2 ? 13'h1080 : (i == 0 ? 13'h0080 : 13'h0500));
         chk("oe", i == 2 ? 24'h7 : 24'(i), 24'({dq_oe_n, dqs_oe_n, dqs_b_oe_n}));
         if (i < 2) chk("lvl", i == 0 ? 24'h6 : 24'h1, 24'({dq, dqs, dqs_b}));
         load(SEL_EMR1, 13'h0000);
         chk("oe", 24'h7, 24'({dq_oe_n, dqs_oe_n, dqs_b_oe_n}));
      end
      // Adjust up past the top, down past the bottom, then each code
      for (i = 0; i < 32; i++) begin
         d = i < 8 ? 4'h5 : (i < 25 ? 4'ha : tail[i-25]);
         u_ctl.adjust(e1, d);
         pu = sat(pu, d[1:0]);
         pd = sat(pd, d[3:2]);
         check_all();
      end
      pu = 8;
      pd = 8;
      load(SEL_EMR1, 13'h0380);
      load(SEL_EMR1, 13'h0000);
      report_and_stop();
   end

   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      report_and_stop();
   end
endmodule // ddrmr_top_tb_top
